// [fpio_top.sv]
// Pad I/O logic for one pad pair: input, output and drive-enable paths, dual-edge
// and 1:4 serial modes, stepped input delay and an AXI4-Lite configuration slave.
// Assumes the core clocks arrive as pins and are oversampled on clk, so they must
// run well below a sixth of the clk rate.
//
// Local design decisions: the AXI4-Lite slave port and the address map.
`timescale 1ns/1ps
`include "fpio_consts.svh"

// Overview of operation
// (R1) Bit 0 normal input; dual-edge rise bit0, fall bit1.
// (R2) Core drives bit 0; dual-edge rise bit0, fall bit1.
// (R3) Deserializer: earliest bit on 0, latest on 3.
// (R4) Serializer sends bit 0 first, bit 3 last.
// (R5) Core drive enable, optionally registered, controls buffer.
// (R6) Core drives complement enable equal to primary enable.
// (R7) Transmit register clock clocks output and enable registers.
// (R8) Separate receive register clock clocks input capture.
// (R9) Serial clocks drive serializer and deserializer separately.
// (R10) Delay steps only when enabled; up or down.
// (R11) Optional delay-adjust enable activates dynamic delay.
// (R12) Delay clear returns counter to initial setting.
// (R13) High-voltage cell bypass feeds only PLL reference.
// (R14) Fast pair bypass feeds clocks, feedback, reference.
// (R15) Fast pair: two single-ended pins or one differential.
// (R16) Resync mode delays falling sample half a period.
// (R17) Each register selects rising or falling edge; only the input, output and enable registers do here.
// (R18) Output register can invert launched data.
// (R19) Delay counter has 64 steps, input only.
// (R20) Delay counter saturates at both ends.
module fpio_top
  import fpio_pkg::*;
#(
  parameter bit FAST_PAIR = 1'b1,
  parameter int ADDR_W    = 8
) (
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output fpio_pkg::fpio_resp_t   s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output fpio_pkg::fpio_resp_t   s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic              tx_reg_clock,
  input  wire logic              rx_reg_clock,
  input  wire logic              tx_serial_clock,
  input  wire logic              rx_serial_clock,
  input  wire fpio_pkg::fpio_nib_t tx_bus,
  input  wire logic              drive_enable,
  input  wire logic              drive_enable_complement,
  output fpio_pkg::fpio_nib_t    rx_bus,
  input  wire logic              n_tx_bit,
  input  wire logic              n_drive_enable,
  output logic                   n_rx_bit,
  output logic                   bypass_tap,
  output logic                   bypass_tap_n,
  input  wire logic              delay_adjust_enable,
  input  wire logic              delay_step_up,
  input  wire logic              delay_counter_clear,
  output fpio_pkg::fpio_dly_t    delay_setting,
  input  wire logic              pad_p_i,
  output logic                   pad_p_o,
  output logic                   pad_p_oe,
  input  wire logic              pad_n_i,
  output logic                   pad_n_o,
  output logic                   pad_n_oe
);
  import fpio_pkg::*;

  localparam int IX_TXC = 0;
  localparam int IX_RXC = 1;
  localparam int IX_TXS = 2;
  localparam int IX_RXS = 3;
  localparam int IX_PP  = 4;
  localparam int IX_PN  = 5;

  function automatic logic pick_edge(input logic fall_sel, input logic rise, input logic fall);
    pick_edge = fall_sel ? fall : rise;
  endfunction

  // Pin sampling: a change counts once stages two and three agree.
  logic [5:0] s2;
  logic [5:0] s3;
  logic [5:0] lvl_q;
  logic [5:0] lvl_d;
  logic [5:0] rise;
  logic [5:0] fall;

  fpio_sync #(.W(6)) u_sync (
    .clk   (clk),
    .rst_n (rst_n),
    .din   ({pad_n_i, pad_p_i, rx_serial_clock, tx_serial_clock, rx_reg_clock, tx_reg_clock}),
    .s2    (s2),
    .s3    (s3)
  );

  always_comb begin
    lvl_d = (s2 & s3) | (lvl_q & (s2 ^ s3));
    rise  = ~lvl_q & s2 & s3;
    fall  = lvl_q & ~s2 & ~s3;
  end

  // Configuration, with serial and differential modes absent on high-voltage cells.
  fpio_ctrl_t ctrl_q;
  fpio_ctrl_t ctrl_d;
  logic       c_serdes;
  logic       c_diff;
  logic       c_dual;

  assign c_serdes = FAST_PAIR & ctrl_q[`FPIO_CTRL_SERDES];
  assign c_diff   = FAST_PAIR & ctrl_q[`FPIO_CTRL_DIFF];
  assign c_dual   = ctrl_q[`FPIO_CTRL_DUAL] & ~c_serdes;

  // Datapath state.
  fpio_nib_t rx_q;
  fpio_nib_t rx_d;
  logic      fall_smp_q;
  logic      fall_smp_d;
  fpio_nib_t des_q;
  fpio_nib_t des_d;
  fpio_nib_t ser_q;
  fpio_nib_t ser_d;
  logic      dhi_q;
  logic      dhi_d;
  logic      dlo_q;
  logic      dlo_d;
  logic      out_q;
  logic      out_d;
  logic      oe_q;
  logic      oe_d;
  logic      oen_q;
  logic      oen_d;
  logic      po_q;
  logic      po_d;
  logic      poe_q;
  logic      poe_d;
  logic      no_q;
  logic      no_d;
  logic      noe_q;
  logic      noe_d;
  logic      nrx_q;
  logic      nrx_d;
  fpio_dly_t dly_q;
  fpio_dly_t dly_d;

  logic in_edge;
  logic out_edge;
  logic oe_edge;
  logic tx_bit;

  always_comb begin
    in_edge  = pick_edge(ctrl_q[`FPIO_CTRL_IN_FALL], rise[IX_RXC], fall[IX_RXC]);   // [R8] [R17]
    out_edge = pick_edge(ctrl_q[`FPIO_CTRL_OUT_FALL], rise[IX_TXC], fall[IX_TXC]);  // [R7] [R17]
    oe_edge  = pick_edge(ctrl_q[`FPIO_CTRL_OE_FALL], rise[IX_TXC], fall[IX_TXC]);   // [R7] [R17]
    tx_bit   = tx_bus[0] ^ ctrl_q[`FPIO_CTRL_OUT_INV];                               // [R18] [R2]

    rx_d       = rx_q;
    fall_smp_d = fall_smp_q;
    des_d      = des_q;
    ser_d      = ser_q;
    dhi_d      = dhi_q;
    dlo_d      = dlo_q;
    out_d      = out_q;
    oe_d       = oe_q;
    oen_d      = oen_q;
    dly_d      = dly_q;

    // Input path.
    if (c_serdes) begin
      if (rise[IX_RXS]) begin
        des_d = {lvl_q[IX_PP], des_q[3:1]};  // [R9] [R3]
      end
      if (rise[IX_RXC]) begin
        rx_d = des_q;  // [R3]
      end
    end else if (c_dual) begin
      if (ctrl_q[`FPIO_CTRL_RESYNC]) begin
        if (fall[IX_RXC]) begin
          fall_smp_d = lvl_q[IX_PP];  // [R16]
        end
        if (rise[IX_RXC]) begin
          rx_d = {2'h0, fall_smp_q, lvl_q[IX_PP]};  // [R16] [R1]
        end
      end else begin
        if (rise[IX_RXC]) begin
          rx_d[0] = lvl_q[IX_PP];  // [R1]
        end
        if (fall[IX_RXC]) begin
          rx_d[1] = lvl_q[IX_PP];  // [R1]
        end
      end
    end else if (ctrl_q[`FPIO_CTRL_IN_REG]) begin
      if (in_edge) begin
        rx_d = {3'h0, lvl_q[IX_PP]};  // [R1]
      end
    end else begin
      rx_d = {3'h0, lvl_q[IX_PP]};  // [R1]
    end

    // Output path.
    if (c_serdes) begin
      if (rise[IX_TXC]) begin
        ser_d = tx_bus ^ {4{ctrl_q[`FPIO_CTRL_OUT_INV]}};  // [R4] [R18]
      end else if (rise[IX_TXS]) begin
        ser_d = {1'b0, ser_q[3:1]};  // [R9] [R4]
      end
      out_d = ser_q[0];  // [R4]
    end else if (c_dual) begin
      if (rise[IX_TXC]) begin
        dhi_d = tx_bit;  // [R2] [R7]
        out_d = dlo_q;
      end
      if (fall[IX_TXC]) begin
        dlo_d = tx_bus[1] ^ ctrl_q[`FPIO_CTRL_OUT_INV];  // [R2] [R7]
        out_d = dhi_q;
      end
    end else if (ctrl_q[`FPIO_CTRL_OUT_REG]) begin
      if (out_edge) begin
        out_d = tx_bit;  // [R7]
      end
    end else begin
      out_d = tx_bit;
    end

    // Drive-enable path.
    if (ctrl_q[`FPIO_CTRL_OE_REG]) begin
      if (oe_edge) begin
        oe_d  = drive_enable;             // [R5] [R7]
        oen_d = drive_enable_complement;  // [R6]
      end
    end else begin
      oe_d  = drive_enable;             // [R5]
      oen_d = drive_enable_complement;  // [R6]
    end

    // Dynamic input delay: stepped once per rising edge of the receive register clock while enabled.
    if (delay_counter_clear) begin
      dly_d = `FPIO_DLY_INIT;  // [R12]
    end else if (FAST_PAIR && delay_adjust_enable && rise[IX_RXC]) begin  // [R11] [R10]
      if (delay_step_up) begin
        if (dly_q != fpio_dly_t'(`FPIO_DLY_STEPS - 1)) begin
          dly_d = dly_q + 6'h01;  // [R10] [R19] [R20]
        end
      end else if (dly_q != 6'h00) begin
        dly_d = dly_q - 6'h01;  // [R10] [R20]
      end
    end
  end

  // Pad drive: the N pin is the complement in differential mode, else its own pin.
  always_comb begin
    po_d  = out_q;
    poe_d = oe_q;
    nrx_d = lvl_q[IX_PN];
    if (c_diff) begin
      no_d  = ~out_q;  // [R15]
      noe_d = oen_q;   // [R15] [R6]
    end else begin
      no_d  = n_tx_bit;       // [R15]
      noe_d = n_drive_enable;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      lvl_q      <= '0;
      rx_q       <= '0;
      fall_smp_q <= 1'b0;
      des_q      <= '0;
      ser_q      <= '0;
      dhi_q      <= 1'b0;
      dlo_q      <= 1'b0;
      out_q      <= 1'b0;
      oe_q       <= 1'b0;
      oen_q      <= 1'b0;
      po_q       <= 1'b0;
      poe_q      <= 1'b0;
      no_q       <= 1'b0;
      noe_q      <= 1'b0;
      nrx_q      <= 1'b0;
      dly_q      <= `FPIO_DLY_INIT;
    end else begin
      lvl_q      <= lvl_d;
      rx_q       <= rx_d;
      fall_smp_q <= fall_smp_d;
      des_q      <= des_d;
      ser_q      <= ser_d;
      dhi_q      <= dhi_d;
      dlo_q      <= dlo_d;
      out_q      <= out_d;
      oe_q       <= oe_d;
      oen_q      <= oen_d;
      po_q       <= po_d;
      poe_q      <= poe_d;
      no_q       <= no_d;
      noe_q      <= noe_d;
      nrx_q      <= nrx_d;
      dly_q      <= dly_d;
    end
  end

  assign rx_bus        = rx_q;
  assign pad_p_o       = po_q;
  assign pad_p_oe      = poe_q;
  assign pad_n_o       = no_q;
  assign pad_n_oe      = noe_q;
  assign n_rx_bit      = nrx_q;
  assign delay_setting = dly_q;
  // The bypass taps skip all capture registers; only the sampling flops remain.
  // Which network they feed is fixed by routing outside this block.
  assign bypass_tap    = lvl_q[IX_PP];                  // [R13] [R14]
  assign bypass_tap_n  = FAST_PAIR & lvl_q[IX_PN];      // [R14]

  // AXI4-Lite slave: address and data are taken in either order, one write at a time.
  logic              awh_q;
  logic              awh_d;
  logic              wh_q;
  logic              wh_d;
  logic [ADDR_W-1:0] awa_q;
  logic [ADDR_W-1:0] awa_d;
  logic [31:0]       wd_q;
  logic [31:0]       wd_d;
  logic [3:0]        ws_q;
  logic [3:0]        ws_d;
  logic              bv_q;
  logic              bv_d;
  fpio_resp_t        br_q;
  fpio_resp_t        br_d;
  logic              rv_q;
  logic              rv_d;
  fpio_resp_t        rr_q;
  fpio_resp_t        rr_d;
  logic [31:0]       rd_q;
  logic [31:0]       rd_d;
  logic [31:0]       status;

  always_comb begin
    status = 32'h0;
    status[`FPIO_ST_RX_LSB +: 4] = rx_q;
    status[`FPIO_ST_PAD_LVL]     = lvl_q[IX_PP];
    status[`FPIO_ST_PAD_OE]      = poe_q;
    status[`FPIO_ST_DLY_LSB +: 6] = dly_q;
  end

  always_comb begin
    awh_d  = awh_q;
    wh_d   = wh_q;
    awa_d  = awa_q;
    wd_d   = wd_q;
    ws_d   = ws_q;
    bv_d   = bv_q;
    br_d   = br_q;
    rv_d   = rv_q;
    rr_d   = rr_q;
    rd_d   = rd_q;
    ctrl_d = ctrl_q;
    if (s_axi_awvalid && !awh_q) begin
      awh_d = 1'b1;
      awa_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && !wh_q) begin
      wh_d = 1'b1;
      wd_d = s_axi_wdata;
      ws_d = s_axi_wstrb;
    end
    if (bv_q && s_axi_bready) begin
      bv_d = 1'b0;
    end
    if (awh_q && wh_q && !bv_q) begin
      awh_d = 1'b0;
      wh_d  = 1'b0;
      bv_d  = 1'b1;
      br_d  = `FPIO_RESP_OKAY;
      if (awa_q == ADDR_W'(`FPIO_CTRL_OFS)) begin
        if (ws_q[0]) begin
          ctrl_d[7:0] = wd_q[7:0];
        end
        if (ws_q[1]) begin
          ctrl_d[`FPIO_CTRL_W-1:8] = wd_q[`FPIO_CTRL_W-1:8];
        end
      end else if (awa_q != ADDR_W'(`FPIO_STATUS_OFS)) begin
        br_d = `FPIO_RESP_SLVERR;
      end
    end
    if (rv_q && s_axi_rready) begin
      rv_d = 1'b0;
    end
    if (s_axi_arvalid && !rv_q) begin
      rv_d = 1'b1;
      rr_d = `FPIO_RESP_OKAY;
      if (s_axi_araddr == ADDR_W'(`FPIO_CTRL_OFS)) begin
        rd_d = {{(32 - `FPIO_CTRL_W){1'b0}}, ctrl_q};
      end else if (s_axi_araddr == ADDR_W'(`FPIO_STATUS_OFS)) begin
        rd_d = status;
      end else begin
        rd_d = 32'h0;
        rr_d = `FPIO_RESP_SLVERR;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      awh_q  <= 1'b0;
      wh_q   <= 1'b0;
      awa_q  <= '0;
      wd_q   <= 32'h0;
      ws_q   <= 4'h0;
      bv_q   <= 1'b0;
      br_q   <= `FPIO_RESP_OKAY;
      rv_q   <= 1'b0;
      rr_q   <= `FPIO_RESP_OKAY;
      rd_q   <= 32'h0;
      ctrl_q <= `FPIO_CTRL_RESET;
    end else begin
      awh_q  <= awh_d;
      wh_q   <= wh_d;
      awa_q  <= awa_d;
      wd_q   <= wd_d;
      ws_q   <= ws_d;
      bv_q   <= bv_d;
      br_q   <= br_d;
      rv_q   <= rv_d;
      rr_q   <= rr_d;
      rd_q   <= rd_d;
      ctrl_q <= ctrl_d;
    end
  end

  assign s_axi_awready = ~awh_q;
  assign s_axi_wready  = ~wh_q;
  assign s_axi_bvalid  = bv_q;
  assign s_axi_bresp   = br_q;
  assign s_axi_arready = ~rv_q;
  assign s_axi_rvalid  = rv_q;
  assign s_axi_rresp   = rr_q;
  assign s_axi_rdata   = rd_q;
endmodule

// [fpio_consts.svh]
// Constants for the fabric pad I/O logic: register offsets, field positions,
// reset values and counts. Included by the package users; holds definitions only.
`ifndef FPIO_CONSTS_SVH
`define FPIO_CONSTS_SVH

`define FPIO_CTRL_OFS       8'h00
`define FPIO_STATUS_OFS     8'h04

`define FPIO_CTRL_IN_REG    0
`define FPIO_CTRL_OUT_REG   1
`define FPIO_CTRL_OE_REG    2
`define FPIO_CTRL_DUAL      3
`define FPIO_CTRL_RESYNC    4
`define FPIO_CTRL_SERDES    5
`define FPIO_CTRL_DIFF      6
`define FPIO_CTRL_OUT_INV   7
`define FPIO_CTRL_IN_FALL   8
`define FPIO_CTRL_OUT_FALL  9
`define FPIO_CTRL_OE_FALL   10
`define FPIO_CTRL_W         11
`define FPIO_CTRL_RESET     11'h000

`define FPIO_ST_RX_LSB      0
`define FPIO_ST_PAD_LVL     4
`define FPIO_ST_PAD_OE      5
`define FPIO_ST_DLY_LSB     8

`define FPIO_DLY_STEPS      64
`define FPIO_DLY_INIT       6'h00

`define FPIO_RESP_OKAY      2'h0
`define FPIO_RESP_SLVERR    2'h2

`endif

// [fpio_pkg.sv]
// Types shared by the fabric pad I/O logic.
// Assumes fpio_consts.svh is on the include path.
`include "fpio_consts.svh"

package fpio_pkg;
  typedef logic [5:0]                 fpio_dly_t;
  typedef logic [3:0]                 fpio_nib_t;
  typedef logic [`FPIO_CTRL_W-1:0]    fpio_ctrl_t;
  typedef logic [1:0]                 fpio_resp_t;
endpackage

// [fpio_sync.sv]
// Three-flop synchroniser for pins and foreign clocks sampled on clk.
// Assumes one clock; the first stage is read only by the second.
`timescale 1ns/1ps

module fpio_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] s2,
  output logic      [W-1:0] s3
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;
  logic [W-1:0] s1_d;
  logic [W-1:0] s2_d;
  logic [W-1:0] s3_d;

  always_comb begin
    s1_d = din;
    s2_d = s1_q;
    s3_d = s2_q;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else begin
      s1_q <= s1_d;
      s2_q <= s2_d;
      s3_q <= s3_d;
    end
  end

  assign s2 = s2_q;
  assign s3 = s3_q;
endmodule

// [fpio_top_asserts.sv]
// Checker for fpio_top: bus answers, delay counter and bypass tap.
// Bound into fpio_top; it sees only that module's ports.
`timescale 1ns/1ps

module fpio_top_asserts
  import fpio_pkg::*;
(
  input wire logic                 clk,
  input wire logic                 rst_n,
  input wire logic                 s_axi_awvalid,
  input wire logic                 s_axi_awready,
  input wire logic                 s_axi_wvalid,
  input wire logic                 s_axi_wready,
  input wire logic                 s_axi_bvalid,
  input wire logic                 s_axi_bready,
  input wire fpio_pkg::fpio_resp_t s_axi_bresp,
  input wire logic                 s_axi_arvalid,
  input wire logic                 s_axi_arready,
  input wire logic                 s_axi_rvalid,
  input wire logic                 s_axi_rready,
  input wire logic [31:0]          s_axi_rdata,
  input wire logic                 delay_adjust_enable,
  input wire logic                 delay_step_up,
  input wire logic                 delay_counter_clear,
  input wire fpio_pkg::fpio_dly_t  delay_setting,
  input wire logic                 pad_p_i,
  input wire logic                 bypass_tap
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered");
  write_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##[1:2] s_axi_bvalid) else $error("write not answered");
  clear_init_a: assert property (delay_counter_clear |=> delay_setting == 6'h00)
    else $error("delay clear ignored");
  idle_hold_a: assert property (!delay_adjust_enable && !delay_counter_clear |=> $stable(delay_setting))
    else $error("delay moved while disabled");
  step_dir_a: assert property (!delay_counter_clear |=> delay_setting == $past(delay_setting) ||
    delay_setting == ($past(delay_step_up) ? $past(delay_setting) + 6'h01
                                            : $past(delay_setting) - 6'h01))
    else $error("delay stepped wrongly");
  top_sat_a: assert property (delay_setting == 6'h3f && !delay_counter_clear |=> delay_setting != 6'h00)
    else $error("delay wrapped at top");
  bot_sat_a: assert property (delay_setting == 6'h00 |=> delay_setting != 6'h3f)
    else $error("delay wrapped at bottom");
  tap_follow_a: assert property ($stable(pad_p_i) [*8] |-> bypass_tap == pad_p_i)
    else $error("bypass tap stale");

  c_top: cover property (delay_setting == 6'h3f);
  c_read: cover property (s_axi_rvalid && s_axi_rready);
  c_write: cover property (s_axi_bvalid && s_axi_bready);
endmodule

bind fpio_top fpio_top_asserts i_fpio_top_asserts (.*);

// [fpio_pad_model.sv]
// Far side of one pad: the outside level meets the cell's output buffer.
// Assumes the bench sets ext_val as the level of the outside world.
`timescale 1ns/1ps

module fpio_pad_model (
  input  wire logic pad_o,
  input  wire logic pad_oe,
  input  wire logic ext_val,
  output logic      pad_i
);
  // The outside driver yields while the cell drives, so contention is not modelled.
  assign pad_i = pad_oe ? pad_o : ext_val;
endmodule

// [fpio_tb_top.sv]
// Self-checking bench for fpio_top: bus, delay counter, input and output paths.
// Assumes the pad model and the bound checker; slow clocks are made here.
`timescale 1ns/1ps
`define CHK(n, e, s) begin compares++; if ((s) !== (e)) begin n_mismatch++; \
  $display("[ERR] %s exp %h got %h", n, e, s); end end

module fpio_tb_top;
  import fpio_pkg::*;
  logic        clk, rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rnd, rd;
  logic [3:0]  s_axi_wstrb, sck;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, up;
  fpio_resp_t  s_axi_bresp, s_axi_rresp, rr;
  logic        tx_reg_clock, rx_reg_clock, tx_serial_clock, rx_serial_clock;
  fpio_nib_t   tx_bus, rx_bus;
  logic        drive_enable, drive_enable_complement, n_tx_bit, n_drive_enable, n_rx_bit;
  logic        bypass_tap, bypass_tap_n, delay_adjust_enable, delay_step_up, delay_counter_clear;
  fpio_dly_t   delay_setting;
  logic        pad_p_i, pad_p_o, pad_p_oe, pad_n_i, pad_n_o, pad_n_oe, ext_p, ext_n;
  int          n_mismatch, compares, dm, i, k, pv;

  assign {rx_serial_clock, tx_serial_clock, rx_reg_clock, tx_reg_clock} = sck;
  fpio_top i_fpio_top (.*);
  fpio_pad_model i_pad_p (.pad_o(pad_p_o), .pad_oe(pad_p_oe), .ext_val(ext_p), .pad_i(pad_p_i));
  fpio_pad_model i_pad_n (.pad_o(pad_n_o), .pad_oe(pad_n_oe), .ext_val(ext_n), .pad_i(pad_n_i));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // Each phase spans ten clk cycles, well above what the pin filters need.
  task automatic sk(input int n, input logic v);
    repeat (4) @(posedge clk);
    sck[n] <= v;
    repeat (6) @(posedge clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input fpio_resp_t e);
    logic aw, w;
    aw = 1'b0;
    w = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw && w)) begin
      @(posedge clk);
      if (s_axi_awvalid && s_axi_awready) begin
        aw = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge clk); while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    `CHK("bresp", e, s_axi_bresp)
    @(posedge clk);
  endtask

  task automatic rdw(input logic [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge clk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge clk); while (!s_axi_rvalid);
    rd = s_axi_rdata;
    rr = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge clk);
  endtask

  task automatic results();
    if (n_mismatch == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  initial begin
    repeat (40000) @(posedge clk);
    n_mismatch++;
    results();
  end

  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, sck, tx_bus} = '0;
    {drive_enable, drive_enable_complement, n_tx_bit, n_drive_enable, ext_p, ext_n} = '0;
    {delay_adjust_enable, delay_step_up, delay_counter_clear, s_axi_awaddr, s_axi_araddr} = '0;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hf;
    rnd = 32'h4c0403bd;
    dm = 0;
    rst_n = 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    rdw(8'h00);
    `CHK("ctrl_rst", 32'h0, rd)
    rdw(8'h10);
    `CHK("unmapped", 2'h2, rr)
    wr(8'h10, 32'hffffffff, 2'h2);
    wr(8'h04, 32'hffffffff, 2'h0);
    rnd = lfsr(rnd);
    wr(8'h00, rnd, 2'h0);
    rdw(8'h00);
    `CHK("ctrl_rw", rnd & 32'h7ff, rd)
    wr(8'h00, 32'h0, 2'h0);
    // Up past the top, down past the bottom, then random steps with a clear.
    delay_adjust_enable <= 1'b1;
    for (i = 0; i < 200; i++) begin
      rnd = lfsr(rnd);
      up = (i < 70) || (i >= 140 && rnd[0]);
      delay_step_up <= up;
      sk(1, 1'b1);
      dm = up ? (dm < 63 ? dm + 1 : 63) : (dm > 0 ? dm - 1 : 0);
      sk(1, 1'b0);
      `CHK("dly", dm[5:0], delay_setting)
      if (i == 170) begin
        delay_counter_clear <= 1'b1;
        @(posedge clk);
        delay_counter_clear <= 1'b0;
        dm = 0;
        repeat (2) @(posedge clk);
        `CHK("dly_clr", 6'h00, delay_setting)
      end
    end
    delay_adjust_enable <= 1'b0;
    sk(1, 1'b1);
    sk(1, 1'b0);
    `CHK("dly_off", dm[5:0], delay_setting)
    rdw(8'h04);
    `CHK("st_dly", dm[5:0], rd[13:8])
    wr(8'h00, 32'h9, 2'h0);
    for (i = 0; i < 4; i++) begin
      ext_p <= i[0];
      sk(1, 1'b1);
      ext_p <= i[1];
      sk(1, 1'b0);
      `CHK("dual_in", i[1:0], rx_bus[1:0])
    end
    // Resync mode: bit 1 carries the fall sample taken before this rise.
    wr(8'h00, 32'h19, 2'h0);
    pv = 0;
    for (i = 0; i < 5; i++) begin
      ext_p <= i[0];
      sk(1, 1'b1);
      if (i > 0) `CHK("resync", {pv[0], i[0]}, rx_bus[1:0])
      ext_p <= i[1];
      sk(1, 1'b0);
      pv = i[1];
    end
    wr(8'h00, 32'h21, 2'h0);
    for (k = 0; k < 3; k++) begin
      rnd = lfsr(rnd);
      for (i = 0; i < 4; i++) begin
        ext_p <= rnd[i];
        sk(3, 1'b1);
        sk(3, 1'b0);
      end
      sk(1, 1'b1);
      sk(1, 1'b0);
      `CHK("deser", rnd[3:0], rx_bus)
    end
    wr(8'h00, 32'h86, 2'h0);
    for (i = 0; i < 2; i++) begin
      tx_bus <= {3'h0, i[0]};
      drive_enable <= 1'b1;
      drive_enable_complement <= 1'b1;
      sk(0, 1'b1);
      sk(0, 1'b0);
      `CHK("out_inv", ~i[0], pad_p_o)
      `CHK("oe_on", 1'b1, pad_p_oe)
    end
    drive_enable <= 1'b0;
    drive_enable_complement <= 1'b0;
    repeat (10) @(posedge clk);
    `CHK("oe_held", 1'b1, pad_p_oe)
    sk(0, 1'b1);
    sk(0, 1'b0);
    `CHK("oe_off", 1'b0, pad_p_oe)
    wr(8'h00, 32'h22, 2'h0);
    rnd = lfsr(rnd);
    tx_bus <= rnd[3:0];
    sk(0, 1'b1);
    sk(0, 1'b0);
    for (i = 0; i < 4; i++) begin
      `CHK("ser", rnd[i], pad_p_o)
      sk(2, 1'b1);
      sk(2, 1'b0);
    end
    wr(8'h00, 32'h40, 2'h0);
    tx_bus <= 4'h1;
    drive_enable <= 1'b1;
    drive_enable_complement <= 1'b1;
    repeat (8) @(posedge clk);
    `CHK("diff_n", 1'b0, pad_n_o)
    `CHK("diff_oe", 1'b1, pad_n_oe)
    wr(8'h00, 32'h0, 2'h0);
    drive_enable <= 1'b0;
    drive_enable_complement <= 1'b0;
    n_tx_bit <= 1'b1;
    n_drive_enable <= 1'b1;
    ext_p <= 1'b1;
    repeat (8) @(posedge clk);
    `CHK("se_n", 1'b1, pad_n_o)
    `CHK("tap", 1'b1, bypass_tap)
    `CHK("n_rx", 1'b1, n_rx_bit)
    `CHK("tap_n", 1'b1, bypass_tap_n)
    results();
  end
endmodule
